// ===== logic/mrb_pkg.sv
// mrb_pkg: shared constants and lane-mask helper for the byte-enabled dual-port ram
// assumes all users run on mclk; widths are fixed at the widest configuration
package mrb_pkg;

	localparam int unsigned MRB_DW      = 144;
	localparam int unsigned MRB_LANES   = 16;
	localparam int unsigned MRB_L9      = 9;
	localparam int unsigned MRB_L8      = 8;
	localparam int unsigned MRB_AW      = 6;
	localparam int unsigned MRB_DEPTH   = 64;

	localparam logic [MRB_DW-1:0]    MRB_DATA_RST = 144'h0;
	localparam logic [MRB_AW-1:0]    MRB_ADDR_RST = 6'h0;
	localparam logic [MRB_LANES-1:0] MRB_BE_RST   = 16'h0;

	// clock source choice for a register stage
	typedef enum logic {
		MRB_SRC_A,
		MRB_SRC_B
	} mrb_src_t;

	// expand lane enables to a bit mask; nine-bit lanes fill 144 bits,
	// eight-bit lanes fill the low 128 bits and never touch the top 16
	function automatic logic [MRB_DW-1:0] mrb_lane_mask(
		input logic [MRB_LANES-1:0] be,
		input logic                 nine
	);
		logic [MRB_DW-1:0] m;
		m = '0;
		for (int n = 0; n < MRB_LANES; n++) begin
			for (int b = 0; b < MRB_L9; b++) begin
				if (nine && be[n])
					m[n*MRB_L9+b] = 1'b1;
				else if (!nine && be[n] && b < MRB_L8)
					m[n*MRB_L8+b] = 1'b1;
			end
		end
		return m;
	endfunction : mrb_lane_mask

endpackage : mrb_pkg

// ===== logic/mrb_port.sv
// mrb_port: input register stage and read-data output stage of one ram port
// assumes tick_in / tick_out are one-cycle strobes on mclk from the selected block clock
`timescale 1ns/1ns
module mrb_port
	import mrb_pkg::*;
(
	// clock and reset
	input  wire logic                        mclk,
	input  wire logic                        rst_b,
	// selected block clock strobes
	input  wire logic                        tick_in,
	input  wire logic                        tick_out,
	// port control
	input  wire logic                        clken,
	input  wire logic                        clr,
	input  wire logic                        renwe,
	input  wire logic                        lane9,
	input  wire logic                        bypass,
	// request
	input  wire logic [mrb_pkg::MRB_AW-1:0]    addr,
	input  wire logic [mrb_pkg::MRB_DW-1:0]    wdata,
	input  wire logic [mrb_pkg::MRB_LANES-1:0] byteen,
	// array side
	input  wire logic [mrb_pkg::MRB_DW-1:0]    rd_word,
	output logic                             wr_go,
	output logic                             rd_go,
	output logic [mrb_pkg::MRB_AW-1:0]         addr_q,
	output logic [mrb_pkg::MRB_DW-1:0]         wdata_q,
	output logic [mrb_pkg::MRB_DW-1:0]         mask_q,
	// read data
	output logic [mrb_pkg::MRB_DW-1:0]         rdata_q
);
	import mrb_pkg::*;

	logic              cap;
	logic [MRB_DW-1:0] pipe_q;

	assign cap = tick_in & clken;

	// every input register moves on the same strobe
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			addr_q  <= MRB_ADDR_RST;
			wdata_q <= MRB_DATA_RST;
			mask_q  <= MRB_DATA_RST;
		end else if (cap) begin
			addr_q  <= addr;
			wdata_q <= wdata;
			mask_q  <= mrb_lane_mask(byteen, lane9);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			wr_go <= 1'b0;
			rd_go <= 1'b0;
		end else begin
			wr_go <= cap & renwe;
			rd_go <= cap & ~renwe;
		end
	end

	// array read latch, fed by the input-side clock
	always_ff @(posedge mclk) begin
		if (!rst_b)
			pipe_q <= MRB_DATA_RST;
		else if (rd_go)
			pipe_q <= rd_word;
	end

	// output register; clear acts at once, not on an edge
	always_ff @(posedge mclk or posedge clr) begin
		if (clr)
			rdata_q <= MRB_DATA_RST;
		else if (!rst_b)
			rdata_q <= MRB_DATA_RST;
		else if (bypass && rd_go)
			rdata_q <= rd_word;
		else if (!bypass && tick_out && clken)
			rdata_q <= pipe_q;
	end

endmodule : mrb_port

// ===== logic/mrb_ram.sv
// mrb_ram: dual-port ram with per-lane write enables and independent port stages
// assumes the two block clocks arrive as one-cycle strobes on mclk from fabric logic
`timescale 1ns/1ns

// Functional notes
// - sixteen lane enables; enable n writes bits 9n..9n+8 in nine-bit mode.
// - any enable pattern allowed; only enabled lanes change, others keep data.
// - in eight-bit mode enable n writes bits 8n..8n+7 of the word.
// - input and output stages may use different block clocks.
// - select, data, address, enables of a port capture together on one clock.
// - output register may be bypassed, giving read data one stage earlier.
module mrb_ram
	import mrb_pkg::*;
(
	// clock and reset
	input  wire logic                          mclk,
	input  wire logic                          rst_b,
	// the two block clocks, as strobes
	input  wire logic                          blk_clk0_tick,
	input  wire logic                          blk_clk1_tick,
	// static configuration
	input  wire logic                          lane9,
	input  wire mrb_pkg::mrb_src_t             in_src_a,
	input  wire mrb_pkg::mrb_src_t             out_src_a,
	input  wire logic                          bypass_a,
	input  wire mrb_pkg::mrb_src_t             in_src_b,
	input  wire mrb_pkg::mrb_src_t             out_src_b,
	input  wire logic                          bypass_b,
	// port a control
	input  wire logic                          clken_a,
	input  wire logic                          clr_a,
	input  wire logic                          renwe_a,
	// port a request
	input  wire logic [mrb_pkg::MRB_AW-1:0]    addr_a,
	input  wire logic [mrb_pkg::MRB_DW-1:0]    wdata_a,
	input  wire logic [mrb_pkg::MRB_LANES-1:0] byteen_a,
	// port b control
	input  wire logic                          clken_b,
	input  wire logic                          clr_b,
	input  wire logic                          renwe_b,
	// port b request
	input  wire logic [mrb_pkg::MRB_AW-1:0]    addr_b,
	input  wire logic [mrb_pkg::MRB_DW-1:0]    wdata_b,
	input  wire logic [mrb_pkg::MRB_LANES-1:0] byteen_b,
	// read data
	output logic [mrb_pkg::MRB_DW-1:0]         rdata_a,
	output logic [mrb_pkg::MRB_DW-1:0]         rdata_b,
	// same-word write from both ports seen
	output logic                               wr_clash_q
);
	import mrb_pkg::*;

	logic [MRB_DW-1:0] mem [MRB_DEPTH];

	logic              tin_a;
	logic              tout_a;
	logic              tin_b;
	logic              tout_b;
	logic              wgo_a;
	logic              wgo_b;
	logic [MRB_AW-1:0] aq_a;
	logic [MRB_AW-1:0] aq_b;
	logic [MRB_DW-1:0] wq_a;
	logic [MRB_DW-1:0] wq_b;
	logic [MRB_DW-1:0] mq_a;
	logic [MRB_DW-1:0] mq_b;
	logic [MRB_DW-1:0] rw_a;
	logic [MRB_DW-1:0] rw_b;

	// strobe of the block clock that a stage is tied to
	function automatic logic pick_tick(
		input mrb_src_t s,
		input logic     t0,
		input logic     t1
	);
		return (s == MRB_SRC_A) ? t0 : t1;
	endfunction : pick_tick

	// keep the old word outside the mask, take the new word inside it
	function automatic logic [MRB_DW-1:0] lane_merge(
		input logic [MRB_DW-1:0] old_w,
		input logic [MRB_DW-1:0] new_w,
		input logic [MRB_DW-1:0] mask
	);
		return (old_w & ~mask) | (new_w & mask);
	endfunction : lane_merge

	// each stage picks its own block clock
	assign tin_a  = pick_tick(in_src_a, blk_clk0_tick, blk_clk1_tick);
	assign tout_a = pick_tick(out_src_a, blk_clk0_tick, blk_clk1_tick);
	assign tin_b  = pick_tick(in_src_b, blk_clk0_tick, blk_clk1_tick);
	assign tout_b = pick_tick(out_src_b, blk_clk0_tick, blk_clk1_tick);

	// read-before-write: a read sees the word as it stood before this edge
	assign rw_a = mem[aq_a];
	assign rw_b = mem[aq_b];

	mrb_port u_port_a (
		.mclk     (mclk),
		.rst_b    (rst_b),
		.tick_in  (tin_a),
		.tick_out (tout_a),
		.clken    (clken_a),
		.clr      (clr_a),
		.renwe    (renwe_a),
		.lane9    (lane9),
		.bypass   (bypass_a),
		.addr     (addr_a),
		.wdata    (wdata_a),
		.byteen   (byteen_a),
		.rd_word  (rw_a),
		.wr_go    (wgo_a),
		.rd_go    (),
		.addr_q   (aq_a),
		.wdata_q  (wq_a),
		.mask_q   (mq_a),
		.rdata_q  (rdata_a)
	);

	mrb_port u_port_b (
		.mclk     (mclk),
		.rst_b    (rst_b),
		.tick_in  (tin_b),
		.tick_out (tout_b),
		.clken    (clken_b),
		.clr      (clr_b),
		.renwe    (renwe_b),
		.lane9    (lane9),
		.bypass   (bypass_b),
		.addr     (addr_b),
		.wdata    (wdata_b),
		.byteen   (byteen_b),
		.rd_word  (rw_b),
		.wr_go    (wgo_b),
		.rd_go    (),
		.addr_q   (aq_b),
		.wdata_q  (wq_b),
		.mask_q   (mq_b),
		.rdata_q  (rdata_b)
	);

	// masked merge; port b is applied last so it wins on a shared lane.
	// contents are not reset: a real ram powers up undefined and resetting
	// 9k flops buys nothing but area
	always_ff @(posedge mclk) begin
		if (wgo_a)
			mem[aq_a] <= lane_merge(mem[aq_a], wq_a, mq_a);
		if (wgo_b && !(wgo_a && aq_a == aq_b))
			mem[aq_b] <= lane_merge(mem[aq_b], wq_b, mq_b);
		if (wgo_b && wgo_a && aq_a == aq_b)
			mem[aq_b] <= lane_merge(lane_merge(mem[aq_b], wq_a, mq_a), wq_b, mq_b);
	end

	// sticky until reset; tells the user a clash was resolved in favour of b
	always_ff @(posedge mclk) begin
		if (!rst_b)
			wr_clash_q <= 1'b0;
		else if (wgo_a && wgo_b && aq_a == aq_b)
			wr_clash_q <= 1'b1;
	end

endmodule : mrb_ram

// ===== verif/mrb_fab.sv
// mrb_fab: fabric model making the two block clock strobes
// assumes mclk runs free; strobes rest low in reset
`timescale 1ns/1ns
module mrb_fab (
	// clock and reset
	input wire logic	mclk,
	input wire logic	rst_b,
	// block clock strobes
	output logic	blk_clk0_tick,
	output logic	blk_clk1_tick
);
	// clock 1 at half rate so the output stage sees a domain of its own
	always_ff @(posedge mclk) begin
		blk_clk0_tick <= rst_b;
		blk_clk1_tick <= rst_b && !blk_clk1_tick;
	end
endmodule : mrb_fab

// ===== verif/mrb_ram_sva.sv
// mrb_ram_sva: port-level checks on the dual-port ram's read data
// assumes port stages are fed by one-cycle block clock strobes on mclk
`timescale 1ns/1ns
module mrb_ram_sva
	import mrb_pkg::*;
(
	// clock and reset
	input wire logic	mclk,
	input wire logic	rst_b,
	// strobes and configuration
	input wire logic	blk_clk0_tick,
	input wire logic	blk_clk1_tick,
	input wire mrb_pkg::mrb_src_t	out_src_a,
	input wire mrb_pkg::mrb_src_t	in_src_b,
	input wire logic	bypass_a,
	input wire logic	bypass_b,
	// port control
	input wire logic	clken_a,
	input wire logic	clken_b,
	input wire logic	clr_a,
	input wire logic	clr_b,
	input wire logic	renwe_b,
	// read data
	input wire logic [mrb_pkg::MRB_DW-1:0]	rdata_a,
	input wire logic [mrb_pkg::MRB_DW-1:0]	rdata_b
);
	wire	otk_a = out_src_a == MRB_SRC_A ? blk_clk0_tick : blk_clk1_tick;
	wire	cap_b = clken_b && (in_src_b == MRB_SRC_A ? blk_clk0_tick : blk_clk1_tick);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	property p_clr_a; clr_a |-> rdata_a == '0; endproperty
	a_clr_a: assert property (p_clr_a) else $error("rdata_a not zero in clear");
	property p_clr_b; clr_b |-> rdata_b == '0; endproperty
	a_clr_b: assert property (p_clr_b) else $error("rdata_b not zero in clear");
	property p_hold_a; !clken_a ##1 !clken_a ##1 !clr_a |-> $stable(rdata_a); endproperty
	a_hold_a: assert property (p_hold_a) else $error("rdata_a moved while idle");
	property p_hold_b; !clken_b ##1 !clken_b ##1 !clr_b |-> $stable(rdata_b); endproperty
	a_hold_b: assert property (p_hold_b) else $error("rdata_b moved while idle");
	// a registered load may only follow an output strobe of its own clock
	property p_reg_a; !bypass_a && !clr_a && $changed(rdata_a) |-> $past(clken_a && otk_a); endproperty
	a_reg_a: assert property (p_reg_a) else $error("rdata_a loaded without out tick");
	property p_byp_b; bypass_b && !clr_b && $changed(rdata_b) |-> $past(cap_b && !renwe_b, 2); endproperty
	a_byp_b: assert property (p_byp_b) else $error("rdata_b change not from read");
	property p_wr_b; bypass_b && cap_b && renwe_b ##2 !clr_b |-> $stable(rdata_b); endproperty
	a_wr_b: assert property (p_wr_b) else $error("write disturbed rdata_b");
endmodule : mrb_ram_sva
bind mrb_ram mrb_ram_sva i_mrb_ram_sva (.mclk, .rst_b, .blk_clk0_tick, .blk_clk1_tick,
	.out_src_a, .in_src_b, .bypass_a, .bypass_b, .clken_a, .clken_b, .clr_a, .clr_b,
	.renwe_b, .rdata_a, .rdata_b);

// ===== verif/tb_top.sv
// tb_top: scenario bench for the byte-enabled dual-port ram
// assumes port a registered on clock 1 out, port b bypassed
`timescale 1ns/1ns
module tb_top;
	import mrb_pkg::*;
	logic	mclk, rst_b, lane9, bypass_a;
	logic [1:0]	ce, cl, we;
	logic [MRB_AW-1:0]	ad [2];
	logic [MRB_DW-1:0]	wd [2];
	logic [15:0]	be [2];
	logic [MRB_DW-1:0]	rda, rdb, e;
	wire logic	t0, t1, clash;
	mrb_src_t	src_a;
	int	mismatches, samples_checked;
	localparam logic [MRB_DW-1:0] D1 = {9{16'h9e37}}, D2 = {9{16'h5c1b}};
	always #5 mclk = ~mclk;
	mrb_fab i_mrb_fab (.mclk, .rst_b, .blk_clk0_tick(t0), .blk_clk1_tick(t1));
	mrb_ram i_mrb_ram (.mclk, .rst_b, .blk_clk0_tick(t0), .blk_clk1_tick(t1), .lane9,
		.in_src_a(src_a), .out_src_a(MRB_SRC_B), .bypass_a,
		.in_src_b(MRB_SRC_A), .out_src_b(MRB_SRC_A), .bypass_b(1'b1),
		.clken_a(ce[0]), .clr_a(cl[0]), .renwe_a(we[0]), .addr_a(ad[0]),
		.wdata_a(wd[0]), .byteen_a(be[0]), .clken_b(ce[1]), .clr_b(cl[1]),
		.renwe_b(we[1]), .addr_b(ad[1]), .wdata_b(wd[1]), .byteen_b(be[1]),
		.rdata_a(rda), .rdata_b(rdb), .wr_clash_q(clash));
	// lane mask built bit by bit, w is the lane width
	function automatic logic [MRB_DW-1:0] lm(input logic [15:0] b, input int w);
		lm = '0;
		for (int i = 0; i < 16 * w; i++) lm[i] = b[i / w];
	endfunction : lm
	task automatic op(input int p, input logic w, input logic [5:0] a,
			input logic [MRB_DW-1:0] d, input logic [15:0] b, input int n);
		ce[p] = 1'b1; we[p] = w; ad[p] = a; wd[p] = d; be[p] = b;
		repeat (n) @(posedge mclk);
		#1;
	endtask : op
	// op leaves ce up so a following op on the same port never re-drives it in one step;
	// the caller drops it once the port goes idle
	task automatic chk(input string nm, input logic [MRB_DW-1:0] x, g);
		samples_checked++;
		if (g !== x) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", nm, x, g);
		end
	endtask : chk
	task automatic chk_flag(input string nm, input logic x, g);
		samples_checked++;
		if (g !== x) begin
			mismatches++;
			$display("CHECK FAILED %s exp %b got %b", nm, x, g);
		end
	endtask : chk_flag
	task automatic rd(input int p, input logic [5:0] a, input logic [MRB_DW-1:0] x, input int n);
		op(p, 1'b0, a, '0, '0, n);
		ce[p] = 1'b0;
		@(posedge mclk);
		#1 chk(p ? "rdata_b" : "rdata_a", x, p ? rdb : rda);
	endtask : rd
	task automatic s_full;
		op(0, 1'b1, 6'h05, D1, 16'hffff, 1);
		ce[0] = 1'b0;
		rd(1, 6'h05, D1, 1);
	endtask : s_full
	task automatic s_lanes;
		e = (D1 & ~lm(16'h5a3c, 9)) | (D2 & lm(16'h5a3c, 9));
		op(0, 1'b1, 6'h05, D2, 16'h5a3c, 1);
		rd(0, 6'h05, e, 4);
	endtask : s_lanes
	// port a input stage on clock 1: a write offered while that strobe is low is not taken
	task automatic s_src;
		src_a = MRB_SRC_B;
		op(0, 1'b1, 6'h22, D2, 16'hffff, 2);
		ce[0] = 1'b0;
		repeat (t1 ? 1 : 2) @(posedge mclk);
		#1 op(0, 1'b1, 6'h22, D1, 16'hffff, 1);
		ce[0] = 1'b0;
		rd(1, 6'h22, D2, 1);
		src_a = MRB_SRC_A;
	endtask : s_src
	task automatic s_eight;
		op(1, 1'b1, 6'h3f, D1, 16'hffff, 1);
		ce[1] = 1'b0;
		@(posedge mclk);
		#1 lane9 = 1'b0;
		op(1, 1'b1, 6'h3f, D2, 16'hc3a5, 1);
		e = (D1 & ~lm(16'hc3a5, 8)) | (D2 & lm(16'hc3a5, 8));
		rd(1, 6'h3f, e, 1);
		bypass_a = 1'b1;
		rd(0, 6'h3f, e, 1);
	endtask : s_eight
	task automatic s_clr;
		repeat (3) @(posedge mclk);
		#1 chk("rdata_a hold", e, rda);
		cl = 2'b11;
		#1 chk("rdata_a clear", '0, rda);
		chk("rdata_b clear", '0, rdb);
		@(posedge mclk);
		#1 cl = 2'b00;
		bypass_a = 1'b0;
		repeat (2) @(posedge mclk);
		#1 chk("rdata_a after clear", '0, rda);
	endtask : s_clr
	// both ports write one word in one cycle, then a reset in mid-run
	task automatic s_clash;
		lane9 = 1'b1;
		fork
			op(0, 1'b1, 6'h11, D1, 16'hffff, 1);
			op(1, 1'b1, 6'h11, D2, 16'h0ff0, 1);
		join
		ce[0] = 1'b0;
		rd(1, 6'h11, (D1 & ~lm(16'h0ff0, 9)) | (D2 & lm(16'h0ff0, 9)), 1);
		chk_flag("wr_clash_q set", 1'b1, clash);
		rst_b = 1'b0;
		repeat (2) @(posedge mclk);
		#1 rst_b = 1'b1;
		chk("rdata_a reset", '0, rda);
		chk("rdata_b reset", '0, rdb);
		chk_flag("wr_clash_q reset", 1'b0, clash);
	endtask : s_clash
	task automatic results;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : results
	initial begin
		#100000 mismatches++;
		results();
	end
	initial begin
		mclk = 0; rst_b = 0; lane9 = 1; bypass_a = 0; ce = 0; cl = 0; we = 0;
		src_a = MRB_SRC_A;
		ad = '{default: '0}; wd = '{default: '0}; be = '{default: '0};
		repeat (12) @(posedge mclk);
		#1 rst_b = 1;
		repeat (2) @(posedge mclk);
		#1 s_full();
		s_lanes();
		s_src();
		s_eight();
		s_clr();
		s_clash();
		results();
	end
endmodule : tb_top
